// >>> hw/uacls_pkg.sv
// constants for the auto clear-to-send and line status uart slice
package uacls_pkg;
	localparam int ADDR_W = 32;
	localparam logic [31:0] ADDR_DATA = 32'he001_0000;
	localparam logic [31:0] ADDR_INT_ENABLE = 32'he001_0004;
	localparam logic [31:0] ADDR_MODEM_CONTROL = 32'he001_0010;
	localparam logic [31:0] ADDR_LINE_STATUS = 32'he001_0014;
	localparam logic [31:0] ADDR_MODEM_STATUS = 32'he001_0018;
	localparam logic [31:0] ADDR_FIFO_LEVEL = 32'he001_001c;
	localparam int IER_MODEM_BIT = 3;
	localparam int IER_CTS_BIT = 7;
	localparam int MCR_DTR_BIT = 0;
	localparam int MCR_RTS_BIT = 1;
	localparam int MCR_AUTO_CTS_BIT = 7;
	localparam int LSR_READY_BIT = 0;
	localparam int LSR_OVERRUN_BIT = 1;
	localparam int MSR_DCTS_BIT = 0;
	localparam int MSR_DDSR_BIT = 1;
	localparam int MSR_TERI_BIT = 2;
	localparam int MSR_DDCD_BIT = 3;
	localparam logic [7:0] IER_RESET = 8'h00;
	localparam logic [7:0] MCR_RESET = 8'h00;
	localparam logic [3:0] DELTA_RESET = 4'h0;
	localparam int BIT_CYCLES_DEFAULT = 16;
	localparam int FIFO_DEPTH_DEFAULT = 16;
	localparam int CHAR_BITS = 8;
	localparam int CNT_W = 16;
	localparam logic [1:0] FRAME_IDLE = 2'b00;
	localparam logic [1:0] FRAME_START = 2'b01;
	localparam logic [1:0] FRAME_DATA = 2'b10;
	localparam logic [1:0] FRAME_STOP = 2'b11;
	typedef enum logic [1:0] {
		UACLS_IDLE = FRAME_IDLE,
		UACLS_START = FRAME_START,
		UACLS_DATA = FRAME_DATA,
		UACLS_STOP = FRAME_STOP
	} uacls_frame_t;
endpackage

// >>> hw/uacls_if.sv
// internal carriers between the controller and the serial engines
`timescale 1ns/100ps
`default_nettype none
interface uacls_tx_if;
	logic valid;
	logic [7:0] data;
	logic permit;
	logic take;
	modport ctl (output valid, output data, output permit, input take);
	modport eng (input valid, input data, input permit, output take);
endinterface

interface uacls_rx_if;
	logic done;
	logic [7:0] data;
	modport ctl (input done, input data);
	modport eng (output done, output data);
endinterface
`default_nettype wire

// >>> hw/uacls_tx.sv
// serial transmitter engine, 8 data bits, one stop bit
`timescale 1ns/100ps
`default_nettype none
module uacls_tx #(
	parameter int BIT_CYCLES = uacls_pkg::BIT_CYCLES_DEFAULT
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	uacls_tx_if.eng txp,
	output var logic tx_o
);
	localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
	uacls_pkg::uacls_frame_t state_r;
	logic [15:0] cnt_r;
	logic [2:0] bitn_r;
	logic [7:0] shreg_r;
	logic take_r;
	logic bit_end;
	assign bit_end = (cnt_r == BIT_LAST);
	assign txp.take = take_r;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= uacls_pkg::UACLS_IDLE;
			cnt_r <= 16'h0000;
			bitn_r <= 3'h0;
			shreg_r <= 8'h00;
			take_r <= 1'b0;
			tx_o <= 1'b1;
		end else begin
			take_r <= 1'b0;
			cnt_r <= bit_end ? 16'h0000 : cnt_r + 16'h0001;
			unique case (state_r)
				uacls_pkg::UACLS_IDLE: begin
					// line marks at 1 while nothing may start
					tx_o <= 1'b1;
					cnt_r <= 16'h0000;
					// level checked before every character, never mid-frame
					if (txp.valid && txp.permit && !take_r) begin
						take_r <= 1'b1;
						shreg_r <= txp.data;
						tx_o <= 1'b0;
						state_r <= uacls_pkg::UACLS_START;
					end
				end
				uacls_pkg::UACLS_START: begin
					if (bit_end) begin
						tx_o <= shreg_r[0];
						shreg_r <= {1'b0, shreg_r[7:1]};
						bitn_r <= 3'h0;
						state_r <= uacls_pkg::UACLS_DATA;
					end
				end
				uacls_pkg::UACLS_DATA: begin
					if (bit_end) begin
						if (bitn_r == 3'h7) begin
							tx_o <= 1'b1;
							state_r <= uacls_pkg::UACLS_STOP;
						end else begin
							tx_o <= shreg_r[0];
							shreg_r <= {1'b0, shreg_r[7:1]};
							bitn_r <= bitn_r + 3'h1;
						end
					end
				end
				uacls_pkg::UACLS_STOP: begin
					// character in progress always completes
					if (bit_end) begin
						state_r <= uacls_pkg::UACLS_IDLE;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> hw/uacls_rx.sv
// serial receiver engine, mid-bit sampling
`timescale 1ns/100ps
`default_nettype none
module uacls_rx #(
	parameter int BIT_CYCLES = uacls_pkg::BIT_CYCLES_DEFAULT
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic rx_i,
	uacls_rx_if.eng rxp
);
	localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
	localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);
	uacls_pkg::uacls_frame_t state_r;
	logic [15:0] cnt_r;
	logic [2:0] bitn_r;
	logic [7:0] shreg_r;
	logic done_r;
	assign rxp.done = done_r;
	assign rxp.data = shreg_r;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= uacls_pkg::UACLS_IDLE;
			cnt_r <= 16'h0000;
			bitn_r <= 3'h0;
			shreg_r <= 8'h00;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			cnt_r <= cnt_r + 16'h0001;
			unique case (state_r)
				uacls_pkg::UACLS_IDLE: begin
					cnt_r <= 16'h0000;
					if (!rx_i) begin
						state_r <= uacls_pkg::UACLS_START;
					end
				end
				uacls_pkg::UACLS_START: begin
					if (cnt_r == HALF_LAST) begin
						cnt_r <= 16'h0000;
						bitn_r <= 3'h0;
						// a glitch shorter than half a bit is not a start
						state_r <= rx_i ? uacls_pkg::UACLS_IDLE : uacls_pkg::UACLS_DATA;
					end
				end
				uacls_pkg::UACLS_DATA: begin
					if (cnt_r == BIT_LAST) begin
						cnt_r <= 16'h0000;
						shreg_r <= {rx_i, shreg_r[7:1]};
						bitn_r <= bitn_r + 3'h1;
						if (bitn_r == 3'h7) begin
							state_r <= uacls_pkg::UACLS_STOP;
						end
					end
				end
				uacls_pkg::UACLS_STOP: begin
					if (cnt_r == BIT_LAST) begin
						done_r <= 1'b1;
						state_r <= uacls_pkg::UACLS_IDLE;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> hw/uacls_top.sv
// uart slice: modem status interrupt, auto clear-to-send, line status
`timescale 1ns/100ps
`default_nettype none
//Contract
// - auto cts on: cts change interrupts only with cts enable; other deltas do whenever the modem interrupt enable is set
// - modem interrupt enable low gives no interrupt; auto cts off, delta cts interrupts
// - under flow control cts changes stay silent unless the cts enable allows
// - auto cts off: every queued character goes out regardless of cts
// - cts sampled before each character; remote releases before mid last stop bit
// - cts high: finish current character, then hold line at 1
// - cts low again: start bit then data of next queued character
// - line status is read-only; writes leave it unchanged
// - bit 0 is 1 while unread data waits, 0 when fifo empty, resets 0
// - bit 1 sets when a character completes into a full fifo, resets 0
// - a line status read clears the overrun flag unless an overrun sets in the same cycle
// - on overrun the fifo is kept and the new character dropped
module uacls_top #(
	parameter int BIT_CYCLES = uacls_pkg::BIT_CYCLES_DEFAULT,
	parameter int RX_DEPTH = uacls_pkg::FIFO_DEPTH_DEFAULT,
	parameter int TX_DEPTH = uacls_pkg::FIFO_DEPTH_DEFAULT
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [31:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output var logic [7:0] rdata_o,
	input wire logic rx_i,
	output var logic tx_o,
	input wire logic clear_to_send_in_n_i,
	input wire logic dsr_n_i,
	input wire logic ri_n_i,
	input wire logic dcd_n_i,
	output var logic rts_n_o,
	output var logic dtr_n_o,
	output var logic modem_irq_o
);
	localparam int RX_AW = $clog2(RX_DEPTH);
	localparam int TX_AW = $clog2(TX_DEPTH);
	localparam logic [RX_AW:0] RX_FULL = (RX_AW + 1)'(RX_DEPTH);
	localparam logic [TX_AW:0] TX_FULL = (TX_AW + 1)'(TX_DEPTH);

	function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
		hit = (a == off);
	endfunction

	uacls_tx_if txc();
	uacls_rx_if rxc();

	logic [7:0] interrupt_enable_reg_r;
	logic [7:0] modem_control_reg_r;
	logic [3:0] delta_r;
	logic [3:0] pins_prev_r;
	logic overrun_r;
	logic [7:0] rx_mem [RX_DEPTH];
	logic [7:0] tx_mem [TX_DEPTH];
	logic [RX_AW-1:0] rx_wp_r;
	logic [RX_AW-1:0] rx_rp_r;
	logic [RX_AW:0] rx_cnt_r;
	logic [TX_AW-1:0] tx_wp_r;
	logic [TX_AW-1:0] tx_rp_r;
	logic [TX_AW:0] tx_cnt_r;
	logic [7:0] rdata_nxt;
	logic [3:0] pins_now;
	logic [3:0] delta_set;
	logic auto_cts;
	logic rx_full;
	logic rx_empty;
	logic tx_full;
	logic rx_push;
	logic rx_pop;
	logic tx_push;
	logic tx_pop;
	logic lsr_read;
	logic msr_read;
	logic overrun_set;
	logic cts_irq_ok;
	logic irq_nxt;

	assign auto_cts = modem_control_reg_r[uacls_pkg::MCR_AUTO_CTS_BIT];
	assign rx_full = (rx_cnt_r == RX_FULL);
	assign rx_empty = (rx_cnt_r == '0);
	assign tx_full = (tx_cnt_r == TX_FULL);

	// pin levels seen as true when asserted (low on the wire)
	assign pins_now = {~dcd_n_i, ~ri_n_i, ~dsr_n_i, ~clear_to_send_in_n_i};

	uacls_tx #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_tx (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.txp(txc),
		.tx_o(tx_o)
	);

	uacls_rx #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_rx (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.rx_i(rx_i),
		.rxp(rxc)
	);

	// transmit queue head offered to the engine
	assign txc.valid = (tx_cnt_r != '0);
	assign txc.data = tx_mem[tx_rp_r];
	// without auto cts the level is ignored entirely
	assign txc.permit = !auto_cts || !clear_to_send_in_n_i;

	assign lsr_read = rd_i && hit(addr_i, uacls_pkg::ADDR_LINE_STATUS);
	assign msr_read = rd_i && hit(addr_i, uacls_pkg::ADDR_MODEM_STATUS);
	assign rx_pop = rd_i && hit(addr_i, uacls_pkg::ADDR_DATA) && !rx_empty;
	// full receive queue is left intact, new character dropped
	assign rx_push = rxc.done && !rx_full;
	assign overrun_set = rxc.done && rx_full;
	// writes to a full transmit queue are dropped
	assign tx_push = wr_i && hit(addr_i, uacls_pkg::ADDR_DATA) && !tx_full;
	assign tx_pop = txc.take;

	// delta detection: cts, dsr, dcd on any change; ring on its trailing edge
	always_comb begin
		delta_set = 4'h0;
		delta_set[uacls_pkg::MSR_DCTS_BIT] = pins_now[0] ^ pins_prev_r[0];
		delta_set[uacls_pkg::MSR_DDSR_BIT] = pins_now[1] ^ pins_prev_r[1];
		delta_set[uacls_pkg::MSR_TERI_BIT] = pins_prev_r[2] && !pins_now[2];
		delta_set[uacls_pkg::MSR_DDCD_BIT] = pins_now[3] ^ pins_prev_r[3];
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pins_prev_r <= 4'h0;
		end else begin
			pins_prev_r <= pins_now;
		end
	end

	// delta flags: a new change beats the clearing read
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			delta_r <= uacls_pkg::DELTA_RESET;
		end else if (msr_read) begin
			delta_r <= delta_set;
		end else begin
			delta_r <= delta_r | delta_set;
		end
	end

	// delta cts is still recorded under flow control, only its interrupt is gated
	assign cts_irq_ok = !auto_cts
		|| interrupt_enable_reg_r[uacls_pkg::IER_CTS_BIT];

	always_comb begin
		irq_nxt = 1'b0;
		if (interrupt_enable_reg_r[uacls_pkg::IER_MODEM_BIT]) begin
			irq_nxt = (delta_r[uacls_pkg::MSR_DCTS_BIT] && cts_irq_ok)
				|| delta_r[uacls_pkg::MSR_DDSR_BIT]
				|| delta_r[uacls_pkg::MSR_TERI_BIT]
				|| delta_r[uacls_pkg::MSR_DDCD_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			modem_irq_o <= 1'b0;
		end else begin
			modem_irq_o <= irq_nxt;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			interrupt_enable_reg_r <= uacls_pkg::IER_RESET;
		end else if (wr_i && hit(addr_i, uacls_pkg::ADDR_INT_ENABLE)) begin
			interrupt_enable_reg_r <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			modem_control_reg_r <= uacls_pkg::MCR_RESET;
		end else if (wr_i && hit(addr_i, uacls_pkg::ADDR_MODEM_CONTROL)) begin
			modem_control_reg_r <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rts_n_o <= 1'b1;
			dtr_n_o <= 1'b1;
		end else begin
			rts_n_o <= !modem_control_reg_r[uacls_pkg::MCR_RTS_BIT];
			dtr_n_o <= !modem_control_reg_r[uacls_pkg::MCR_DTR_BIT];
		end
	end

	// overrun: a set in the same cycle as the clearing read wins
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			overrun_r <= 1'b0;
		end else if (overrun_set) begin
			overrun_r <= 1'b1;
		end else if (lsr_read) begin
			overrun_r <= 1'b0;
		end
	end

	// receive queue
	always_ff @(posedge clk_i) begin
		if (rx_push) begin
			rx_mem[rx_wp_r] <= rxc.data;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_wp_r <= '0;
			rx_rp_r <= '0;
			rx_cnt_r <= '0;
		end else begin
			if (rx_push) begin
				rx_wp_r <= (rx_wp_r == RX_AW'(RX_DEPTH - 1)) ? '0 : rx_wp_r + 1'b1;
			end
			if (rx_pop) begin
				rx_rp_r <= (rx_rp_r == RX_AW'(RX_DEPTH - 1)) ? '0 : rx_rp_r + 1'b1;
			end
			if (rx_push && !rx_pop) begin
				rx_cnt_r <= rx_cnt_r + 1'b1;
			end else if (rx_pop && !rx_push) begin
				rx_cnt_r <= rx_cnt_r - 1'b1;
			end
		end
	end

	// transmit queue
	always_ff @(posedge clk_i) begin
		if (tx_push) begin
			tx_mem[tx_wp_r] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_wp_r <= '0;
			tx_rp_r <= '0;
			tx_cnt_r <= '0;
		end else begin
			if (tx_push) begin
				tx_wp_r <= (tx_wp_r == TX_AW'(TX_DEPTH - 1)) ? '0 : tx_wp_r + 1'b1;
			end
			if (tx_pop) begin
				tx_rp_r <= (tx_rp_r == TX_AW'(TX_DEPTH - 1)) ? '0 : tx_rp_r + 1'b1;
			end
			if (tx_push && !tx_pop) begin
				tx_cnt_r <= tx_cnt_r + 1'b1;
			end else if (tx_pop && !tx_push) begin
				tx_cnt_r <= tx_cnt_r - 1'b1;
			end
		end
	end

	// read mux; line status has no write path at all
	always_comb begin
		rdata_nxt = 8'h00;
		if (hit(addr_i, uacls_pkg::ADDR_DATA)) begin
			rdata_nxt = rx_empty ? 8'h00 : rx_mem[rx_rp_r];
		end else if (hit(addr_i, uacls_pkg::ADDR_INT_ENABLE)) begin
			rdata_nxt = interrupt_enable_reg_r;
		end else if (hit(addr_i, uacls_pkg::ADDR_MODEM_CONTROL)) begin
			rdata_nxt = modem_control_reg_r;
		end else if (hit(addr_i, uacls_pkg::ADDR_LINE_STATUS)) begin
			rdata_nxt[uacls_pkg::LSR_READY_BIT] = !rx_empty;
			rdata_nxt[uacls_pkg::LSR_OVERRUN_BIT] = overrun_r;
		end else if (hit(addr_i, uacls_pkg::ADDR_MODEM_STATUS)) begin
			rdata_nxt = {pins_now, delta_r};
		end else if (hit(addr_i, uacls_pkg::ADDR_FIFO_LEVEL)) begin
			rdata_nxt = {4'(tx_cnt_r), 4'(rx_cnt_r)};
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			rdata_o <= rdata_nxt;
		end else begin
			rdata_o <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// >>> verification/uacls_props.sv
// concurrent checks on the uart slice top ports
`timescale 1ns/100ps
`default_nettype none
module uacls_props #(
	parameter int BIT_CYCLES = 16
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [31:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic tx_o,
	input wire logic clear_to_send_in_n_i,
	input wire logic dsr_n_i,
	input wire logic ri_n_i,
	input wire logic dcd_n_i,
	input wire logic modem_irq_o
);
	localparam int FRAME_CYC = 11 * BIT_CYCLES + 4;
	logic ier3_r, ier7_r, mcr7_r;
	logic [3:0] oth_r, pin_r;
	logic [15:0] blk_r;
	logic lsr_rd, msr_rd;
	assign lsr_rd = rd_i && addr_i == uacls_pkg::ADDR_LINE_STATUS;
	assign msr_rd = rd_i && addr_i == uacls_pkg::ADDR_MODEM_STATUS;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	// shadows of the config bits, the bodies are not visible here
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ier3_r <= 1'b0;
			ier7_r <= 1'b0;
		end else if (wr_i && addr_i == uacls_pkg::ADDR_INT_ENABLE) begin
			ier3_r <= wdata_i[3];
			ier7_r <= wdata_i[7];
		end
	end
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mcr7_r <= 1'b0;
		end else if (wr_i && addr_i == uacls_pkg::ADDR_MODEM_CONTROL) begin
			mcr7_r <= wdata_i[7];
		end
	end
	// age of the last non-cts pin move or register write
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			oth_r <= 4'h0;
		end else if (wr_i || $changed(dsr_n_i) || $changed(dcd_n_i) || $changed(ri_n_i)) begin
			oth_r <= 4'h0;
		end else if (oth_r != 4'hf) begin
			oth_r <= oth_r + 4'h1;
		end
	end
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_r <= 4'h0;
		end else if ($changed(dsr_n_i) || $changed(dcd_n_i) || $changed(ri_n_i)
				|| $changed(clear_to_send_in_n_i)) begin
			pin_r <= 4'h0;
		end else if (pin_r != 4'hf) begin
			pin_r <= pin_r + 4'h1;
		end
	end
	// blocked time; restarts on any write so a late mode switch is tolerated
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			blk_r <= 16'h0000;
		end else if (wr_i || !mcr7_r || !clear_to_send_in_n_i) begin
			blk_r <= 16'h0000;
		end else if (blk_r != 16'hffff) begin
			blk_r <= blk_r + 16'h0001;
		end
	end
	sequence s_irq_soon;
		##[1:3] modem_irq_o;
	endsequence
	sequence s_cts_evt;
		$changed(clear_to_send_in_n_i) && ier3_r && (!mcr7_r || ier7_r);
	endsequence
	sequence s_oth_evt;
		($changed(dsr_n_i) || $changed(dcd_n_i) || $rose(ri_n_i)) && ier3_r;
	endsequence
	property p_cts_irq;
		s_cts_evt |-> s_irq_soon;
	endproperty
	a_cts_irq: assert property (p_cts_irq) else $error("cts change gave no irq");
	property p_oth_irq;
		s_oth_evt |-> s_irq_soon;
	endproperty
	a_oth_irq: assert property (p_oth_irq) else $error("pin change gave no irq");
	property p_irq_off;
		!ier3_r |=> !modem_irq_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
	property p_cts_quiet;
		$rose(modem_irq_o) && mcr7_r && !ier7_r |-> oth_r < 4'h5;
	endproperty
	a_cts_quiet: assert property (p_cts_quiet) else $error("irq from cts under flow");
	property p_irq_clear;
		msr_rd && pin_r > 4'h4 |=> ##1 !modem_irq_o;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("irq kept after clear");
	property p_tx_hold;
		blk_r > FRAME_CYC |-> tx_o;
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx not held high");
	property p_lsr_hi;
		lsr_rd |=> rdata_o[7:2] == 6'h00;
	endproperty
	a_lsr_hi: assert property (p_lsr_hi) else $error("line status upper bits set");
	property p_rd_idle;
		!rd_i |=> rdata_o == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
endmodule
bind uacls_top uacls_props #(.BIT_CYCLES(BIT_CYCLES)) u_props (
	.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_o(tx_o),
	.clear_to_send_in_n_i(clear_to_send_in_n_i), .dsr_n_i(dsr_n_i),
	.ri_n_i(ri_n_i), .dcd_n_i(dcd_n_i), .modem_irq_o(modem_irq_o)
);
`default_nettype wire

// >>> verification/uacls_remote.sv
// remote serial partner: drives rx and clear-to-send, decodes tx
`timescale 1ns/100ps
`default_nettype none
module uacls_remote #(
	parameter int BIT_CYCLES = 4
) (
	input wire logic clk_i,
	input wire logic tx_i,
	output logic rx_o,
	output logic cts_n_o
);
	logic [7:0] got[$];
	logic [7:0] b;
	initial begin
		rx_o = 1'b1;
		cts_n_o = 1'b0;
	end
	// caller releases only while idle or early in a frame
	task automatic set_cts(input logic v);
		@(posedge clk_i);
		cts_n_o <= v;
	endtask
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			rx_o <= f[i];
			repeat (BIT_CYCLES - 1) @(posedge clk_i);
		end
	endtask
	// mid-bit sampling on the falling edge keeps clear of update races
	initial begin
		forever begin
			@(negedge clk_i);
			if (!tx_i) begin
				repeat (BIT_CYCLES / 2) @(negedge clk_i);
				for (int j = 0; j < 8; j++) begin
					repeat (BIT_CYCLES) @(negedge clk_i);
					b[j] = tx_i;
				end
				repeat (BIT_CYCLES) @(negedge clk_i);
				got.push_back(b);
			end
		end
	end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the uart slice
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_top;
	localparam int BC = 4;
	localparam logic [31:0] A_DATA = uacls_pkg::ADDR_DATA;
	localparam logic [31:0] A_IER = uacls_pkg::ADDR_INT_ENABLE;
	localparam logic [31:0] A_MCR = uacls_pkg::ADDR_MODEM_CONTROL;
	localparam logic [31:0] A_LSR = uacls_pkg::ADDR_LINE_STATUS;
	localparam logic [31:0] A_MSR = uacls_pkg::ADDR_MODEM_STATUS;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [31:0] addr_i = 32'h0000_0000;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic dsr_n_i = 1'b1;
	logic ri_n_i = 1'b1;
	logic dcd_n_i = 1'b1;
	logic [7:0] rdata_o;
	logic rx_i, tx_o, cts_n, irq;
	logic rts_n, dtr_n;
	logic [7:0] exp_q[$];
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	always #5 clk_i = ~clk_i;
	uacls_top #(.BIT_CYCLES(BC), .RX_DEPTH(4), .TX_DEPTH(4)) DUT (
		.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_i), .tx_o(tx_o),
		.clear_to_send_in_n_i(cts_n), .dsr_n_i(dsr_n_i), .ri_n_i(ri_n_i),
		.dcd_n_i(dcd_n_i), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .modem_irq_o(irq)
	);
	uacls_remote #(.BIT_CYCLES(BC)) rem (
		.clk_i(clk_i), .tx_i(tx_o), .rx_o(rx_i), .cts_n_o(cts_n)
	);
	task automatic test_done();
		if (fail_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rdc(input logic [31:0] a, input logic [7:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		`CHK(rdata_o, e)
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic chk_irq(input logic e);
		@(negedge clk_i);
		`CHK(irq, e)
	endtask
	function automatic logic [7:0] msr(input logic [3:0] d);
		return {~dcd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n, d};
	endfunction
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			fail_count++;
			test_done();
		end
	end
	initial begin
		cyc(4);
		resetn_i <= 1'b1;
		rdc(A_LSR, 8'h00);
		wr(A_LSR, 8'hff);
		rdc(A_LSR, 8'h00);
		rdc(A_MSR, 8'h11);
		rdc(32'he001_0008, 8'h00);
		`CHK({rts_n, dtr_n}, 2'b11)
		wr(A_MCR, 8'h03);
		cyc(1);
		@(negedge clk_i);
		`CHK({rts_n, dtr_n}, 2'b00)
		rdc(A_MCR, 8'h03);
		for (int i = 0; i < 8; i++) begin
			wr(A_IER, {i[1], 3'h0, i[0], 3'h0});
			wr(A_MCR, {i[2], 7'h00});
			rem.set_cts(~cts_n);
			cyc(4);
			chk_irq(i[0] && (!i[2] || i[1]));
			rdc(A_MSR, msr(4'h1));
			cyc(2);
			chk_irq(1'b0);
			@(posedge clk_i);
			{dcd_n_i, dsr_n_i} <= {dcd_n_i ^ i[0], dsr_n_i ^ !i[0]};
			cyc(4);
			chk_irq(i[0]);
			rdc(A_MSR, msr(i[0] ? 4'h8 : 4'h2));
			cyc(2);
		end
		wr(A_IER, 8'h08);
		wr(A_MCR, 8'h00);
		@(posedge clk_i);
		ri_n_i <= 1'b0;
		cyc(4);
		chk_irq(1'b0);
		@(posedge clk_i);
		ri_n_i <= 1'b1;
		cyc(4);
		chk_irq(1'b1);
		rdc(A_MSR, msr(4'h4));
		wr(A_IER, 8'h00);
		rem.set_cts(1'b1);
		wr(A_DATA, 8'h5a);
		wr(A_DATA, 8'ha5);
		cyc(120);
		`CHK(rem.got.size(), 2)
		wr(A_MCR, 8'h80);
		wr(A_DATA, 8'h3c);
		cyc(100);
		`CHK(rem.got.size(), 2)
		rem.set_cts(1'b0);
		cyc(60);
		`CHK(rem.got.size(), 3)
		wr(A_DATA, 8'h11);
		wr(A_DATA, 8'h22);
		for (int n = 0; n < 20 && tx_o; n++)
			@(negedge clk_i);
		rem.set_cts(1'b1);
		cyc(100);
		`CHK(rem.got.size(), 4)
		`CHK(tx_o, 1'b1)
		rem.set_cts(1'b0);
		cyc(60);
		exp_q = '{8'h5a, 8'ha5, 8'h3c, 8'h11, 8'h22};
		`CHK(rem.got.size(), 5)
		foreach (exp_q[k])
			`CHK(rem.got[k], exp_q[k])
		wr(A_MCR, 8'h00);
		rem.send(8'h81);
		cyc(BC);
		rdc(A_LSR, 8'h01);
		rdc(A_DATA, 8'h81);
		rdc(A_LSR, 8'h00);
		for (int k = 0; k < 5; k++)
			rem.send(8'h40 + k[7:0]);
		// clearing read lands on the edge that sets overrun
		addr_i <= A_LSR;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		`CHK(rdata_o, 8'h01)
		wr(A_LSR, 8'h00);
		rdc(A_LSR, 8'h03);
		rdc(A_LSR, 8'h01);
		for (int k = 0; k < 4; k++)
			rdc(A_DATA, 8'h40 + k[7:0]);
		rdc(A_LSR, 8'h00);
		test_done();
	end
endmodule
`default_nettype wire
